// ==== core/mid_decode_timing.sv ====
// Purpose: instruction fetch, decode, execute and cycle timing of the core
// Assumes: program memory and register file answer combinationally
// Notes: one instruction cycle is 2 or 4 clk_sys periods
//
// What this block does
// RL1 - fetch and decode 13-bit words of opcode plus operand fields
// RL2 - ordinary instructions finish in one instruction cycle of two or four clocks
// RL3 - arithmetic or logic writes to the program counter take two cycles
// RL4 - jumps, calls, returns and true skips take two instruction cycles
// RL5 - any result written into the program counter costs two cycles
// RL6 - period option low gives two clocks per cycle, high gives four
// RL7 - timer source ticks at clock over four when four-clock cycles used
// RL8 - any register bit can be set, cleared or tested by instruction
// RL9 - register instructions treat I/O registers like general registers
// RL10 - literals are 8 bits for data, 10 bits for branch targets
// RL11 - power-down clears watchdog, stops oscillator, updates time-out flags
// RL12 - plain return pops program counter and leaves flags alone
// RL13 - interrupt return pops program counter and re-enables interrupts
// RL14 - software interrupt pushes next address and jumps to address one
// RL15 - a taken hardware interrupt continues at address eight
// RL16 - zero, carry, digit carry change only for opcodes that affect them
`timescale 1ns/1ps
`default_nettype none
module mid_decode_timing #(
  parameter int STACK_DEPTH = mid_pkg::STACK_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic instr_period_select,
  input wire logic [mid_pkg::INSTR_W-1:0] prog_word,
  input wire logic [mid_pkg::DATA_W-1:0] reg_rd_data,
  input wire logic irq_req,
  input wire logic wake_req,
  output logic [mid_pkg::PC_W-1:0] fetch_addr_ff,
  output logic [mid_pkg::RADDR_W-1:0] reg_addr_ff,
  output logic reg_wr_en_ff,
  output logic [mid_pkg::DATA_W-1:0] reg_wr_data_ff,
  output logic [mid_pkg::DATA_W-1:0] acc_ff,
  output logic flag_z_ff,
  output logic flag_c_ff,
  output logic flag_dc_ff,
  output logic flag_to_ff,
  output logic flag_pd_ff,
  output logic gie_ff,
  output logic wdog_clear_ff,
  output logic osc_stop_ff,
  output logic timer_tick_ff
);

  localparam logic [2:0] SP_LAST = 3'(STACK_DEPTH - 1);

  ////////////////////////////////////////////////////////////////////////////
  // state

  mid_pkg::mid_cyc_t state_ff;
  mid_pkg::mid_cyc_t nxt_state;
  logic period_ff;
  logic [1:0] phase_ff;
  logic [1:0] last_phase;
  logic exec_now;
  logic [mid_pkg::INSTR_W-1:0] ir_ff;
  logic int_take_ff;
  logic [2:0] sp_ff;
  logic [2:0] top_addr;
  logic [mid_pkg::PC_W-1:0] stack_top;

  // decode results
  logic [7:0] r_val;
  logic [7:0] k8;
  logic [7:0] bit_mask;
  logic [9:0] pc_inc;
  logic [9:0] nxt_pc;
  logic [7:0] res;
  logic [9:0] alu;
  logic [7:0] daa_adj;
  logic wr_r;
  logic wr_a;
  logic set_z;
  logic set_c;
  logic set_dc;
  logic c_val;
  logic dc_val;
  logic two_cyc;
  logic push;
  logic pop;
  logic [9:0] push_val;
  logic gie_set;
  logic gie_clr;
  logic sleep_op;
  logic wdtc_op;
  logic [1:0] grp;
  logic [2:0] sub;

  // returns {carry, digit carry, sum}
  function automatic logic [9:0] add_f(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input logic cin);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
    return {hi[4], lo[4], hi[3:0], lo[3:0]};
  endfunction

  assign last_phase = period_ff ? mid_pkg::PH_LAST_4 : mid_pkg::PH_LAST_2; // RL6
  assign exec_now = (state_ff == mid_pkg::MID_CS_RUN) && (phase_ff == last_phase);
  assign top_addr = (sp_ff == 3'h0) ? SP_LAST : sp_ff - 3'h1;
  assign grp = ir_ff[mid_pkg::F_GRP_LSB +: 2];
  assign sub = ir_ff[mid_pkg::F_SUB_LSB +: 3];

  ////////////////////////////////////////////////////////////////////////////
  // execute decode

  always_comb begin
    // the program counter low byte answers reads of its register address
    r_val = (reg_addr_ff == mid_pkg::R_PC) ? fetch_addr_ff[7:0] // RL9
                                           : reg_rd_data;
    k8 = ir_ff[7:0]; // RL10
    bit_mask = 8'h01 << ir_ff[mid_pkg::F_BIT_LSB +: 3];
    pc_inc = fetch_addr_ff + 10'h001;
    nxt_pc = pc_inc;
    res = 8'h00;
    alu = 10'h000;
    daa_adj = 8'h00;
    wr_r = 1'b0;
    wr_a = 1'b0;
    set_z = 1'b0;
    set_c = 1'b0;
    set_dc = 1'b0;
    c_val = flag_c_ff;
    dc_val = flag_dc_ff;
    two_cyc = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    push_val = pc_inc;
    gie_set = 1'b0;
    gie_clr = 1'b0;
    sleep_op = 1'b0;
    wdtc_op = 1'b0;
    if (int_take_ff) begin
      // fetched word is dropped and its own address is saved
      push = 1'b1;
      push_val = fetch_addr_ff;
      nxt_pc = mid_pkg::VEC_IRQ; // RL15
      gie_clr = 1'b1;
      two_cyc = 1'b1;
    end else if (ir_ff[mid_pkg::F_LONG]) begin
      if (!ir_ff[mid_pkg::F_LITOP]) begin
        push = !ir_ff[mid_pkg::F_JMP];
        nxt_pc = ir_ff[9:0]; // RL10
        two_cyc = 1'b1; // RL4
      end else begin
        case (ir_ff[mid_pkg::F_LSUB_LSB +: 3])
          mid_pkg::L_MOV: begin
            res = k8;
            wr_a = 1'b1;
          end
          mid_pkg::L_OR: begin
            res = acc_ff | k8;
            wr_a = 1'b1;
            set_z = 1'b1;
          end
          mid_pkg::L_AND: begin
            res = acc_ff & k8;
            wr_a = 1'b1;
            set_z = 1'b1;
          end
          mid_pkg::L_XOR: begin
            res = acc_ff ^ k8;
            wr_a = 1'b1;
            set_z = 1'b1;
          end
          mid_pkg::L_RETL: begin
            res = k8;
            wr_a = 1'b1;
            pop = 1'b1;
            nxt_pc = stack_top;
            two_cyc = 1'b1; // RL4
          end
          mid_pkg::L_SUB: begin
            alu = add_f(k8, ~acc_ff, 1'b1);
            res = alu[7:0];
            wr_a = 1'b1;
            {set_z, set_c, set_dc} = 3'h7; // RL16
          end
          mid_pkg::L_SWI: begin
            if (k8 == mid_pkg::SWI_LOW) begin
              push = 1'b1;
              nxt_pc = mid_pkg::VEC_SWI; // RL14
              two_cyc = 1'b1;
            end
          end
          default: begin
            alu = add_f(acc_ff, k8, 1'b0);
            res = alu[7:0];
            wr_a = 1'b1;
            {set_z, set_c, set_dc} = 3'h7; // RL16
          end
        endcase
        c_val = alu[9];
        dc_val = alu[8];
      end
    end else begin
      case (grp)
        mid_pkg::GRP_ALU: begin
          wr_r = ir_ff[mid_pkg::F_DEST];
          wr_a = !ir_ff[mid_pkg::F_DEST];
          case (sub)
            mid_pkg::A_MOV: begin
              res = acc_ff;
              if (!ir_ff[mid_pkg::F_DEST]) begin
                // all-zero group holds the control opcodes
                wr_a = 1'b0;
                case (ir_ff[5:0])
                  mid_pkg::SP_DAA: begin
                    daa_adj[3:0] = (flag_dc_ff ||
                      acc_ff[3:0] > mid_pkg::DAA_LO_LIM) ? mid_pkg::DAA_ADJ
                                                          : 4'h0;
                    daa_adj[7:4] = (flag_c_ff ||
                      acc_ff > mid_pkg::DAA_HI_LIM) ? mid_pkg::DAA_ADJ : 4'h0;
                    alu = add_f(acc_ff, daa_adj, 1'b0);
                    res = alu[7:0];
                    wr_a = 1'b1;
                    set_c = 1'b1; // RL16
                  end
                  mid_pkg::SP_SLEEP: sleep_op = 1'b1; // RL11
                  mid_pkg::SP_WDTC: wdtc_op = 1'b1;
                  mid_pkg::SP_ENI: gie_set = 1'b1;
                  mid_pkg::SP_DISI: gie_clr = 1'b1;
                  mid_pkg::SP_RET, mid_pkg::SP_POP_AND_UNMASK_OP: begin
                    pop = 1'b1;
                    nxt_pc = stack_top; // RL12
                    two_cyc = 1'b1; // RL4
                    gie_set = ir_ff[0]; // RL13
                  end
                  default: res = acc_ff;
                endcase
                c_val = flag_c_ff | alu[9];
              end
            end
            mid_pkg::A_CLR: begin
              res = 8'h00;
              set_z = 1'b1;
            end
            mid_pkg::A_SUB: begin
              alu = add_f(r_val, ~acc_ff, 1'b1);
              res = alu[7:0];
              {set_z, set_c, set_dc} = 3'h7; // RL16
            end
            mid_pkg::A_DEC: begin
              res = r_val - 8'h01;
              set_z = 1'b1;
            end
            mid_pkg::A_OR: begin
              res = acc_ff | r_val;
              set_z = 1'b1;
            end
            mid_pkg::A_AND: begin
              res = acc_ff & r_val;
              set_z = 1'b1;
            end
            mid_pkg::A_XOR: begin
              res = acc_ff ^ r_val;
              set_z = 1'b1;
            end
            default: begin
              alu = add_f(acc_ff, r_val, 1'b0);
              res = alu[7:0];
              {set_z, set_c, set_dc} = 3'h7; // RL16
            end
          endcase
          if (sub == mid_pkg::A_SUB || sub == mid_pkg::A_ADD) begin
            c_val = alu[9];
            dc_val = alu[8];
          end
        end
        mid_pkg::GRP_UNARY: begin
          wr_r = ir_ff[mid_pkg::F_DEST];
          wr_a = !ir_ff[mid_pkg::F_DEST];
          case (sub)
            mid_pkg::U_MOV: begin
              res = r_val;
              set_z = 1'b1;
            end
            mid_pkg::U_COM: begin
              res = ~r_val;
              set_z = 1'b1;
            end
            mid_pkg::U_INC: begin
              res = r_val + 8'h01;
              set_z = 1'b1;
            end
            mid_pkg::U_DJZ: res = r_val - 8'h01;
            mid_pkg::U_RRC: begin
              res = {flag_c_ff, r_val[7:1]};
              c_val = r_val[0];
              set_c = 1'b1;
            end
            mid_pkg::U_RLC: begin
              res = {r_val[6:0], flag_c_ff};
              c_val = r_val[7];
              set_c = 1'b1;
            end
            mid_pkg::U_SWAP: res = {r_val[3:0], r_val[7:4]};
            default: res = r_val + 8'h01;
          endcase
          if ((sub == mid_pkg::U_DJZ || sub == mid_pkg::U_JZ) &&
              res == 8'h00) begin
            nxt_pc = fetch_addr_ff + 10'h002;
            two_cyc = 1'b1; // RL4
          end
        end
        mid_pkg::GRP_BITW: begin
          // hardware does the read-modify-write of the whole register
          res = ir_ff[mid_pkg::F_BITVAL] ? (r_val | bit_mask) // RL8
                                         : (r_val & ~bit_mask);
          wr_r = 1'b1;
        end
        default: begin
          if (((r_val & bit_mask) != 8'h00) == ir_ff[mid_pkg::F_BITVAL]) begin
            nxt_pc = fetch_addr_ff + 10'h002; // RL8
            two_cyc = 1'b1; // RL4
          end
        end
      endcase
    end
    if (wr_r && reg_addr_ff == mid_pkg::R_PC) begin
      nxt_pc = {fetch_addr_ff[9:8], res};
      two_cyc = 1'b1; // RL3 RL5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cycle timing

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      period_ff <= 1'b0;
      phase_ff <= 2'h0;
      timer_tick_ff <= 1'b0;
    end else begin
      timer_tick_ff <= 1'b0;
      if (state_ff == mid_pkg::MID_CS_SLEEP) begin
        phase_ff <= 2'h0;
      end else if (phase_ff == last_phase) begin
        // option only switches on a cycle boundary so no cycle is torn
        period_ff <= instr_period_select; // RL6
        phase_ff <= 2'h0;
        timer_tick_ff <= 1'b1; // RL7 RL2
      end else begin
        phase_ff <= phase_ff + 2'h1;
      end
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      mid_pkg::MID_CS_RUN: begin
        if (exec_now && sleep_op && !int_take_ff) begin
          nxt_state = mid_pkg::MID_CS_SLEEP;
        end else if (exec_now && two_cyc) begin
          nxt_state = mid_pkg::MID_CS_STALL;
        end
      end
      mid_pkg::MID_CS_STALL: begin
        if (phase_ff == last_phase) begin
          nxt_state = mid_pkg::MID_CS_RUN;
        end
      end
      mid_pkg::MID_CS_SLEEP: begin
        if (wake_req) begin
          nxt_state = mid_pkg::MID_CS_RUN;
        end
      end
      default: nxt_state = mid_pkg::MID_CS_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= mid_pkg::MID_CS_RUN;
      osc_stop_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      osc_stop_ff <= (nxt_state == mid_pkg::MID_CS_SLEEP); // RL11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fetch and operand address

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ir_ff <= '0;
      reg_addr_ff <= '0;
      int_take_ff <= 1'b0;
    end else if (state_ff == mid_pkg::MID_CS_RUN && phase_ff == 2'h0) begin
      ir_ff <= prog_word; // RL1
      reg_addr_ff <= prog_word[mid_pkg::RADDR_W-1:0]; // RL9
      int_take_ff <= irq_req && gie_ff; // RL15
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fetch_addr_ff <= mid_pkg::RESET_PC;
    end else if (exec_now) begin
      fetch_addr_ff <= nxt_pc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // results and flags

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff <= mid_pkg::RST_ACC;
      flag_z_ff <= 1'b0;
      flag_c_ff <= 1'b0;
      flag_dc_ff <= 1'b0;
    end else if (exec_now && !int_take_ff) begin
      if (wr_a) begin
        acc_ff <= res;
      end
      if (set_z) begin
        flag_z_ff <= (res == 8'h00); // RL16
      end
      if (set_c) begin
        flag_c_ff <= c_val; // RL16
      end
      if (set_dc) begin
        flag_dc_ff <= dc_val; // RL16
      end
    end
  end

  // the program counter register is never written to the register file
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_wr_en_ff <= 1'b0;
      reg_wr_data_ff <= '0;
    end else begin
      reg_wr_en_ff <= exec_now && !int_take_ff && wr_r &&
                      reg_addr_ff != mid_pkg::R_PC; // RL9
      if (exec_now && wr_r) begin
        reg_wr_data_ff <= res;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gie_ff <= mid_pkg::RST_GIE;
      flag_to_ff <= mid_pkg::RST_TO;
      flag_pd_ff <= mid_pkg::RST_PD;
      wdog_clear_ff <= 1'b0;
    end else begin
      wdog_clear_ff <= exec_now && !int_take_ff && (sleep_op || wdtc_op);
      if (exec_now && gie_clr) begin
        gie_ff <= 1'b0;
      end else if (exec_now && gie_set) begin
        gie_ff <= 1'b1; // RL13
      end
      if (exec_now && !int_take_ff && (sleep_op || wdtc_op)) begin
        flag_to_ff <= 1'b1; // RL11
        flag_pd_ff <= wdtc_op;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // return stack

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sp_ff <= 3'h0;
    end else if (exec_now && push) begin
      sp_ff <= (sp_ff == SP_LAST) ? 3'h0 : sp_ff + 3'h1; // RL14
    end else if (exec_now && pop) begin
      sp_ff <= top_addr; // RL12
    end
  end

  // depth overflow wraps and overwrites the oldest entry
  mid_stack_mem #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(mid_pkg::PC_W),
    .AW(3)
  ) u_stack (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_en(exec_now && push),
    .wr_addr(sp_ff),
    .wr_data(push_val),
    .rd_addr(top_addr),
    .rd_data_ff(stack_top)
  );

endmodule
`default_nettype wire

// ==== core/mid_pkg.sv ====
// Purpose: shared constants and types for the instruction decode and timing
// Assumes: 13-bit program words, 10-bit program counter, 8-bit data path
// Notes: opcode sub-codes follow the bit layout of the instruction word
package mid_pkg;

  localparam int INSTR_W = 13;
  localparam int PC_W = 10;
  localparam int DATA_W = 8;
  localparam int RADDR_W = 6;
  localparam int STACK_DEPTH = 5;

  // field positions inside the instruction word
  localparam int F_LONG = 12;
  localparam int F_LITOP = 11;
  localparam int F_JMP = 10;
  localparam int F_GRP_LSB = 10;
  localparam int F_SUB_LSB = 7;
  localparam int F_DEST = 6;
  localparam int F_BITVAL = 9;
  localparam int F_BIT_LSB = 6;
  localparam int F_LSUB_LSB = 8;

  // reset values and fixed addresses
  localparam logic [PC_W-1:0] RESET_PC = 10'h000;
  localparam logic [PC_W-1:0] VEC_SWI = 10'h001;
  localparam logic [PC_W-1:0] VEC_IRQ = 10'h008;
  localparam logic [RADDR_W-1:0] R_PC = 6'h02;
  localparam logic [DATA_W-1:0] RST_ACC = 8'h00;
  localparam logic RST_TO = 1'b1;
  localparam logic RST_PD = 1'b1;
  localparam logic RST_GIE = 1'b0;

  // oscillator clocks per instruction cycle, as last phase index
  localparam logic [1:0] PH_LAST_2 = 2'h1;
  localparam logic [1:0] PH_LAST_4 = 2'h3;

  // special opcodes in the all-zero group, low six bits, then the 8-bit software interrupt literal
  localparam logic [5:0] SP_DAA = 6'h01;
  localparam logic [5:0] SP_SLEEP = 6'h03;
  localparam logic [5:0] SP_WDTC = 6'h04;
  localparam logic [5:0] SP_ENI = 6'h10;
  localparam logic [5:0] SP_DISI = 6'h11;
  localparam logic [5:0] SP_RET = 6'h12;
  localparam logic [5:0] SP_POP_AND_UNMASK_OP = 6'h13;
  localparam logic [7:0] SWI_LOW = 8'h01;

  // register-operand groups
  localparam logic [1:0] GRP_ALU = 2'h0;
  localparam logic [1:0] GRP_UNARY = 2'h1;
  localparam logic [1:0] GRP_BITW = 2'h2;
  localparam logic [1:0] GRP_BITT = 2'h3;

  // sub-codes of the ALU group
  localparam logic [2:0] A_MOV = 3'h0;
  localparam logic [2:0] A_CLR = 3'h1;
  localparam logic [2:0] A_SUB = 3'h2;
  localparam logic [2:0] A_DEC = 3'h3;
  localparam logic [2:0] A_OR = 3'h4;
  localparam logic [2:0] A_AND = 3'h5;
  localparam logic [2:0] A_XOR = 3'h6;
  localparam logic [2:0] A_ADD = 3'h7;

  // sub-codes of the unary group
  localparam logic [2:0] U_MOV = 3'h0;
  localparam logic [2:0] U_COM = 3'h1;
  localparam logic [2:0] U_INC = 3'h2;
  localparam logic [2:0] U_DJZ = 3'h3;
  localparam logic [2:0] U_RRC = 3'h4;
  localparam logic [2:0] U_RLC = 3'h5;
  localparam logic [2:0] U_SWAP = 3'h6;
  localparam logic [2:0] U_JZ = 3'h7;

  // sub-codes of the literal group
  localparam logic [2:0] L_MOV = 3'h0;
  localparam logic [2:0] L_OR = 3'h1;
  localparam logic [2:0] L_AND = 3'h2;
  localparam logic [2:0] L_XOR = 3'h3;
  localparam logic [2:0] L_RETL = 3'h4;
  localparam logic [2:0] L_SUB = 3'h5;
  localparam logic [2:0] L_SWI = 3'h6;
  localparam logic [2:0] L_ADD = 3'h7;

  // decimal adjust limits
  localparam logic [7:0] DAA_HI_LIM = 8'h99;
  localparam logic [3:0] DAA_LO_LIM = 4'h9;
  localparam logic [3:0] DAA_ADJ = 4'h6;

  typedef enum logic [2:0] {
    MID_CS_RUN = 3'b001,
    MID_CS_STALL = 3'b010,
    MID_CS_SLEEP = 3'b100
  } mid_cyc_t;

endpackage

// ==== core/mid_stack_mem.sv ====
// Purpose: small return-address store for calls and interrupts
// Assumes: one write port, one read port, read data registered
// Notes: contents are not reset; only the read register and the pointer outside are
`timescale 1ns/1ps
`default_nettype none
module mid_stack_mem #(
  parameter int DEPTH = 5,
  parameter int WIDTH = 10,
  parameter int AW = 3
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data_ff
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read follows the pointer one clock late; pointer settles well before use
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= '0;
    end else begin
      rd_data_ff <= mem[rd_addr];
    end
  end

endmodule
`default_nettype wire

// ==== sim/mid_decode_timing_assertions.sv ====
// Purpose: timing checks on the decode core ports
// Assumes: period select only changes while in reset
// Notes: sleep may hold the tick off, so it ends each tick window
`timescale 1ns/1ps
`default_nettype none
module mid_chk #(
  parameter int STACK_DEPTH = 5
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic instr_period_select,
  input wire logic wake_req,
  input wire logic [mid_pkg::PC_W-1:0] fetch_addr_ff,
  input wire logic reg_wr_en_ff,
  input wire logic flag_to_ff,
  input wire logic flag_pd_ff,
  input wire logic wdog_clear_ff,
  input wire logic osc_stop_ff,
  input wire logic timer_tick_ff
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_tick_two_clk: assert property (
    timer_tick_ff && !instr_period_select && !osc_stop_ff |=>
    !timer_tick_ff ##1 (timer_tick_ff || osc_stop_ff))
    else $error("tick spacing wrong in two clock mode");
  a_tick_four_clk: assert property (
    timer_tick_ff && instr_period_select && !osc_stop_ff |=>
    (!timer_tick_ff)[*3] ##1 (timer_tick_ff || osc_stop_ff))
    else $error("tick spacing wrong in four clock mode");
  a_sleep_flags: assert property (
    $rose(osc_stop_ff) |-> !flag_pd_ff && flag_to_ff && wdog_clear_ff)
    else $error("power down entry flags wrong");
  a_wake_release: assert property (
    osc_stop_ff && wake_req |=> !osc_stop_ff)
    else $error("oscillator not restarted on wake");
  a_sleep_no_tick: assert property (
    osc_stop_ff && $past(osc_stop_ff) |-> !timer_tick_ff)
    else $error("tick while stopped");
  a_sleep_pc_hold: assert property (
    osc_stop_ff && $past(osc_stop_ff) |-> $stable(fetch_addr_ff))
    else $error("program counter moved while stopped");
  a_write_at_exec: assert property (
    reg_wr_en_ff |-> timer_tick_ff)
    else $error("register write off the execute edge");
  a_pc_at_exec: assert property (
    $changed(fetch_addr_ff) && !$past(osc_stop_ff) |-> timer_tick_ff)
    else $error("program counter changed off the execute edge");
  c_sleep: cover property ($rose(osc_stop_ff));
  c_four: cover property (timer_tick_ff && instr_period_select);
  c_write: cover property (reg_wr_en_ff);
endmodule
bind mid_decode_timing mid_chk #(.STACK_DEPTH(STACK_DEPTH)) u_chk (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .instr_period_select(instr_period_select),
  .wake_req(wake_req),
  .fetch_addr_ff(fetch_addr_ff),
  .reg_wr_en_ff(reg_wr_en_ff),
  .flag_to_ff(flag_to_ff),
  .flag_pd_ff(flag_pd_ff),
  .wdog_clear_ff(wdog_clear_ff),
  .osc_stop_ff(osc_stop_ff),
  .timer_tick_ff(timer_tick_ff)
);
`default_nettype wire

// ==== sim/mid_mem_model.sv ====
// Purpose: program memory and register file beside the core
// Assumes: combinational reads, register writes on the clock edge
// Notes: blank words read as zero, like unprogrammed space
`timescale 1ns/1ps
`default_nettype none
module mid_mem_model (
  input wire logic clk_sys,
  input wire logic [9:0] fetch_addr_ff,
  input wire logic [5:0] reg_addr_ff,
  input wire logic reg_wr_en_ff,
  input wire logic [7:0] reg_wr_data_ff,
  output logic [12:0] prog_word,
  output logic [7:0] reg_rd_data
);
  // cleared by initialiser so the bench can load words at time zero safely
  logic [12:0] rom [0:1023] = '{default: 13'h0000};
  logic [7:0] regs [0:63] = '{default: 8'h00};
  assign prog_word = rom[fetch_addr_ff];
  // every address behaves alike, so I/O places act as plain registers
  assign reg_rd_data = regs[reg_addr_ff];
  always @(posedge clk_sys) begin
    if (reg_wr_en_ff) begin
      regs[reg_addr_ff] <= reg_wr_data_ff;
    end
  end
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// Purpose: runs one program in both period modes and traces the pc
// Assumes: partner memory answers at once
// Notes: pc spacing is checked against period times cycle count
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic instr_period_select = 1'b0;
  logic irq_req = 1'b0;
  logic wake_req = 1'b0;
  logic [12:0] prog_word;
  logic [7:0] reg_rd_data, reg_wr_data_ff, acc_ff;
  logic [9:0] fetch_addr_ff, prev_pc;
  logic [5:0] reg_addr_ff;
  logic reg_wr_en_ff, flag_to_ff, flag_pd_ff, gie_ff, osc_stop_ff;
  logic flag_z_ff, flag_c_ff, flag_dc_ff;
  logic [31:0] rnd = 32'h86171BB6;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  int last_chg = 0;
  int idx = 0;
  int per = 2;
  logic [9:0] exp_pc [$] = '{10'h010, 10'h011, 10'h001, 10'h012, 10'h013,
    10'h014, 10'h005, 10'h020, 10'h006, 10'h008};
  int ncyc [$] = '{2, 1, 2, 2, 1, 1, 2, 2, 2, 2};
  always #25 clk_sys = ~clk_sys;
  mid_decode_timing uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .instr_period_select(instr_period_select), .prog_word(prog_word),
    .reg_rd_data(reg_rd_data), .irq_req(irq_req), .wake_req(wake_req),
    .fetch_addr_ff(fetch_addr_ff), .reg_addr_ff(reg_addr_ff),
    .reg_wr_en_ff(reg_wr_en_ff), .reg_wr_data_ff(reg_wr_data_ff),
    .acc_ff(acc_ff), .flag_z_ff(flag_z_ff), .flag_c_ff(flag_c_ff),
    .flag_dc_ff(flag_dc_ff),
    .flag_to_ff(flag_to_ff), .flag_pd_ff(flag_pd_ff), .gie_ff(gie_ff),
    .wdog_clear_ff(), .osc_stop_ff(osc_stop_ff), .timer_tick_ff());
  mid_mem_model u_mem (.clk_sys(clk_sys), .fetch_addr_ff(fetch_addr_ff),
    .reg_addr_ff(reg_addr_ff), .reg_wr_en_ff(reg_wr_en_ff),
    .reg_wr_data_ff(reg_wr_data_ff), .prog_word(prog_word),
    .reg_rd_data(reg_rd_data));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wait_pc(input logic [9:0] v);
    int n;
    n = 0;
    while (fetch_addr_ff !== v && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    chk(fetch_addr_ff, v);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // each pc step must come one or two instruction cycles after the last
  always @(negedge clk_sys) begin
    cyc++;
    if (rst_n === 1'b1 && fetch_addr_ff !== prev_pc && idx < 10) begin
      chk(fetch_addr_ff, exp_pc[idx]);
      if (idx > 0)
        chk(cyc - last_chg, per * ncyc[idx - 1]);
      if (idx == 3)
        chk(gie_ff, 1'b1);
      last_chg = cyc;
      idx++;
    end
    prev_pc = fetch_addr_ff;
  end
  task automatic run(input logic sel);
    logic [7:0] k;
    @(posedge clk_sys);
    rst_n <= 1'b0;
    instr_period_select <= sel;
    wake_req <= 1'b0;
    irq_req <= 1'b0;
    rnd = xs(rnd);
    // odd literal so the bit test on it always skips
    k = rnd[7:0] | 8'h01;
    u_mem.rom[16] = {5'h18, k};
    per = sel ? 4 : 2;
    idx = 0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    wait_pc(10'h008);
    repeat (3 * per) @(negedge clk_sys);
    chk(osc_stop_ff, 1'b1);
    chk(flag_pd_ff, 1'b0);
    chk(flag_to_ff, 1'b1);
    chk(acc_ff, 8'h05);
    chk(u_mem.regs[5], k);
    chk(idx, 10);
    // no opcode in this program may touch zero, carry or digit carry
    chk({flag_z_ff, flag_c_ff, flag_dc_ff}, 3'h0);
    @(posedge clk_sys);
    wake_req <= 1'b1;
    @(posedge clk_sys);
    wake_req <= 1'b0;
    irq_req <= 1'b1;
    @(negedge clk_sys);
    chk(osc_stop_ff, 1'b0);
    wait_pc(10'h009);
    wait_pc(10'h008);
    chk(gie_ff, 1'b0);
  endtask
  initial begin
    u_mem.rom[0] = 13'h1410;
    u_mem.rom[1] = 13'h0013;
    u_mem.rom[5] = 13'h1020;
    u_mem.rom[6] = 13'h0E05;
    u_mem.rom[8] = 13'h0003;
    u_mem.rom[9] = 13'h1409;
    u_mem.rom[17] = 13'h1E01;
    u_mem.rom[18] = 13'h0045;
    u_mem.rom[19] = 13'h1805;
    u_mem.rom[20] = 13'h0042;
    u_mem.rom[32] = 13'h0012;
    run(1'b0);
    run(1'b1);
    print_verdict();
  end
  initial begin
    #400000;
    mismatches++;
    print_verdict();
  end
endmodule
`default_nettype wire
